// ---- pkg/link_sync_pkg.sv ----
// Package: register map, field layouts and configuration tables for the link configuration and capture block.
package link_sync_pkg;

    // Register addresses.
    localparam logic [11:0] ADDR_SYSREF_CONTROL_A   = 12'h120;
    localparam logic [11:0] ADDR_SYSREF_CONTROL_B   = 12'h121;
    localparam logic [11:0] ADDR_SYSREF_MARGIN      = 12'h128;
    localparam logic [11:0] ADDR_LINE_RATE_CONTROL  = 12'h56E;
    localparam logic [11:0] ADDR_LINK_QUICK_CONFIG  = 12'h570;
    localparam logic [11:0] ADDR_LINK_FRAMES_PER_MF = 12'h571;
    localparam logic [11:0] ADDR_LINK_PARAMS        = 12'h572;
    localparam logic [11:0] ADDR_IRQ_STATUS         = 12'h580;
    localparam logic [11:0] ADDR_IRQ_MASK           = 12'h581;
    localparam logic [11:0] ADDR_LINE_RATE_STATUS   = 12'h582;
    localparam logic [11:0] ADDR_DECIMATION         = 12'h583;

    // Reset values.
    localparam logic [7:0] RST_CONTROL_A    = 8'h00;
    localparam logic [7:0] RST_CONTROL_B    = 8'h00;
    localparam logic [7:0] RST_LINE_RATE    = 8'h00;
    localparam logic [7:0] RST_QUICK_CONFIG = 8'h88;
    localparam logic [7:0] RST_FRAMES_MF    = 8'h20;
    localparam logic [7:0] RST_DECIMATION   = 8'h01;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;

    // Field positions.
    localparam int POS_POLARITY     = 0;
    localparam int POS_CLOCK_EDGE   = 1;
    localparam int POS_ONE_SHOT     = 2;
    localparam int POS_LOW_RATE     = 4;
    localparam int SKIP_LSB         = 0;
    localparam int SKIP_MSB         = 3;
    localparam int NIBBLE_W         = 4;

    // Interrupt status bit positions.
    localparam int IRQ_CAPTURE      = 0;
    localparam int IRQ_SETUP_ERR    = 1;
    localparam int IRQ_HOLD_ERR     = 2;
    localparam int IRQ_BAD_CONFIG   = 3;

    // Margin interpretation constants.
    localparam logic [3:0] MARGIN_ZERO  = 4'h0;
    localparam logic [3:0] MARGIN_MID   = 4'h8;
    localparam logic [3:0] SETUP_LOW_MAX = 4'h7;
    localparam logic [3:0] HOLD_HIGH_MIN = 4'h9;

    // Lane-rate multipliers and K ranges.
    localparam logic [4:0] RATE_MULT_ONE_LANE  = 5'h14;
    localparam logic [4:0] RATE_MULT_TWO_LANE  = 5'h0A;
    localparam logic [4:0] RATE_MULT_FOUR_LANE = 5'h05;
    localparam logic [5:0] K_MIN_F1 = 6'h14;
    localparam logic [5:0] K_MIN_F2 = 6'h0C;
    localparam logic [5:0] K_MIN_F4 = 6'h08;
    localparam logic [5:0] K_MAX    = 6'h20;
    localparam logic [1:0] K_STEP_MASK = 2'h3;

    // Link parameters of one quick-configuration code.
    typedef struct packed {
        logic       valid;
        logic [2:0] lanes;
        logic [2:0] octets;
        logic [3:0] samples;
        logic [4:0] rate_mult;
    } link_cfg_t;

    // Register bus request.
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Quick-configuration decode.
    function automatic link_cfg_t decode_quick(input logic [7:0] code);
        link_cfg_t c;
        c = '0;
        unique case (code)
            8'h09:   c = '{1'b1, 3'h1, 3'h2, 4'h1, RATE_MULT_ONE_LANE};
            8'h48:   c = '{1'b1, 3'h2, 3'h1, 4'h1, RATE_MULT_TWO_LANE};
            8'h49:   c = '{1'b1, 3'h2, 3'h2, 4'h2, RATE_MULT_TWO_LANE};
            8'h88:   c = '{1'b1, 3'h4, 3'h1, 4'h2, RATE_MULT_FOUR_LANE};
            8'h89:   c = '{1'b1, 3'h4, 3'h2, 4'h4, RATE_MULT_FOUR_LANE};
            8'h8A:   c = '{1'b1, 3'h4, 3'h4, 4'h8, RATE_MULT_FOUR_LANE};
            default: c = '0;
        endcase
        return c;
    endfunction

endpackage

// ---- src/link_sync.sv ----
// Link configuration decode, SYSREF capture with skip counting, margin monitor and register file.
//
// Summary of operation
// - Quick code 0x09/0x48/0x49/0x88/0x89/0x8A selects lanes, octets and samples per frame.
// - Lane rate multiplier is 20, 10 or 5 for one, two or four lanes.
// - Frames per multiframe: steps of four, from 20, 12 or 8 up to 32.
// - A captured SYSREF aligns divider, down-converters, monitor and link framing.
// - Capture event is a rising or falling SYSREF transition, by polarity setting.
// - SYSREF is synchronised on the rising clock edge; the falling setting takes a falling-edge copy of that level.
// - A programmed number of events, up to 15, is ignored before acting.
// - Polarity, edge and skip count sit in two consecutive control registers.
// - Status holds setup margin in bits 3:0 and hold margin in 7:4.
// - Hold zero with setup 0 to 7 flags a possible setup error.
// - Setup zero with hold 9 to F flags a possible hold error.
// - Setup 8, or hold 8 with setup 0 or 9 to F, is a clean capture.
// - Both fields zero flags a possible setup or hold error.
// - Resolution is 7 to 8 bits, control bits 0 to 1, high density off; the block fixes 8 bits and 0 control bits.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns

module link_sync #(
    parameter int SKIP_W = 4
) (
    // Clock and reset.
    input  wire logic                        clock,
    input  wire logic                        srst,
    // Register port.
    input  wire link_sync_pkg::reg_req_t     reg_req,
    output logic [7:0]                       reg_rdata,
    // SYSREF pin and phase detector nibbles from the clock input stage.
    input  wire logic                        sysref_pin,
    input  wire logic [3:0]                  setup_phase,
    input  wire logic [3:0]                  hold_phase,
    // Alignment strobes to the divider, down-converters, monitor and framer.
    output logic                             align_divider,
    output logic                             align_ddc,
    output logic                             align_monitor,
    output logic                             align_framer,
    // Decoded link settings.
    output link_sync_pkg::link_cfg_t         link_cfg,
    output logic [5:0]                       frames_per_mf,
    output logic                             low_rate_mode,
    output logic                             high_density,
    output logic [3:0]                       resolution_bits,
    output logic [1:0]                       control_bits,
    // Interrupt.
    output logic                             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0]          control_a_reg;
    logic [7:0]          control_b_reg;
    logic [7:0]          line_rate_reg;
    logic [7:0]          quick_reg;
    logic [5:0]          kfm_reg;
    logic [7:0]          decim_reg;
    logic [7:0]          margin_reg;
    logic [3:0]          irq_status_reg;
    logic [3:0]          irq_mask_reg;
    logic [3:0]          irq_status_next;
    logic                sync_a_reg;
    logic                sync_b_reg;
    logic                sync_b_fall_reg;
    logic                prev_reg;
    logic [SKIP_W:0]     skip_count_reg;
    logic                armed_reg;
    logic                align_reg;
    logic [7:0]          rdata_reg;
    logic                sampled;
    logic                event_seen;
    logic                act;
    logic [3:0]          setup_f;
    logic [3:0]          hold_f;
    logic                setup_err;
    logic                hold_err;
    logic                either_err;
    logic                cfg_bad;
    link_sync_pkg::link_cfg_t cfg_now;

    wire logic wr = reg_req.wr;
    wire logic rd = reg_req.rd;

    // Checks a frames-per-multiframe value against the octet count.
    function automatic logic kfm_legal(input logic [5:0] k, input logic [2:0] octets);
        logic [5:0] kmin;
        kmin = link_sync_pkg::K_MIN_F1;
        if (octets == 3'h2) begin
            kmin = link_sync_pkg::K_MIN_F2;
        end else if (octets == 3'h4) begin
            kmin = link_sync_pkg::K_MIN_F4;
        end
        return (k >= kmin) && (k <= link_sync_pkg::K_MAX) && ((k[1:0] & link_sync_pkg::K_STEP_MASK) == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    // Software writes; an illegal K write is dropped so the framer never sees it.
    always_ff @(posedge clock) begin
        if (srst) begin
            control_a_reg <= link_sync_pkg::RST_CONTROL_A;
            control_b_reg <= link_sync_pkg::RST_CONTROL_B;
            line_rate_reg <= link_sync_pkg::RST_LINE_RATE;
            quick_reg     <= link_sync_pkg::RST_QUICK_CONFIG;
            kfm_reg       <= link_sync_pkg::RST_FRAMES_MF[5:0];
            decim_reg     <= link_sync_pkg::RST_DECIMATION;
            irq_mask_reg  <= 4'h0;
        end else if (wr) begin
            unique case (reg_req.addr)
                link_sync_pkg::ADDR_SYSREF_CONTROL_A:  control_a_reg <= reg_req.wdata;
                link_sync_pkg::ADDR_SYSREF_CONTROL_B:  control_b_reg <= reg_req.wdata;
                link_sync_pkg::ADDR_LINE_RATE_CONTROL: line_rate_reg <= reg_req.wdata;
                link_sync_pkg::ADDR_LINK_QUICK_CONFIG: quick_reg     <= reg_req.wdata;
                link_sync_pkg::ADDR_LINK_FRAMES_PER_MF: begin
                    if (kfm_legal(reg_req.wdata[5:0], cfg_now.octets) && reg_req.wdata[7:6] == 2'h0) begin
                        kfm_reg <= reg_req.wdata[5:0];
                    end
                end
                link_sync_pkg::ADDR_DECIMATION: begin
                    if (reg_req.wdata != link_sync_pkg::ZERO_BYTE) begin
                        decim_reg <= reg_req.wdata;
                    end
                end
                link_sync_pkg::ADDR_IRQ_MASK:          irq_mask_reg  <= reg_req.wdata[3:0];
                default: ;
            endcase
        end
    end

    // Decoded link setting drives the framer directly.
    always_comb begin
        cfg_now = link_sync_pkg::decode_quick(quick_reg);
    end

    // An unknown quick code, or a K unfit for the octet count, is flagged.
    assign cfg_bad         = !cfg_now.valid || !kfm_legal(kfm_reg, cfg_now.octets);
    assign link_cfg        = cfg_now;
    assign frames_per_mf   = kfm_reg;
    assign low_rate_mode   = line_rate_reg[link_sync_pkg::POS_LOW_RATE];
    assign high_density    = 1'b0;
    assign resolution_bits = 4'h8;
    assign control_bits    = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // SYSREF synchroniser and edge selection.

    // Two flops on the rising edge; the second flop alone feeds anything else.
    always_ff @(posedge clock) begin
        if (srst) begin
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
        end else begin
            sync_a_reg <= sysref_pin;
            sync_b_reg <= sync_a_reg;
        end
    end

    // Falling-edge copy of the synchronised level.
    always_ff @(negedge clock) begin
        if (srst) begin
            sync_b_fall_reg <= 1'b0;
        end else begin
            sync_b_fall_reg <= sync_b_reg;
        end
    end

    assign sampled = control_a_reg[link_sync_pkg::POS_CLOCK_EDGE] ? sync_b_fall_reg : sync_b_reg;

    // Previous sample for transition detection.
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sampled;
        end
    end

    // Polarity zero takes a rising transition, one takes a falling one.
    assign event_seen = control_a_reg[link_sync_pkg::POS_POLARITY] ? (prev_reg && !sampled)
                                                                   : (!prev_reg && sampled);

    ////////////////////////////////////////////////////////////////////////////
    // Skip counter and alignment.

    // Act once the programmed number of events has passed.
    assign act = event_seen && armed_reg &&
                 (skip_count_reg >= {1'b0, control_b_reg[link_sync_pkg::SKIP_MSB:link_sync_pkg::SKIP_LSB]});

    // Writing either control register restarts the skip count and rearms capture.
    always_ff @(posedge clock) begin
        if (srst) begin
            skip_count_reg <= '0;
            armed_reg      <= 1'b1;
        end else if (wr && (reg_req.addr == link_sync_pkg::ADDR_SYSREF_CONTROL_A ||
                            reg_req.addr == link_sync_pkg::ADDR_SYSREF_CONTROL_B)) begin
            skip_count_reg <= '0;
            armed_reg      <= 1'b1;
        end else if (event_seen && armed_reg && !act) begin
            skip_count_reg <= skip_count_reg + 1'b1;
        end else if (act && control_a_reg[link_sync_pkg::POS_ONE_SHOT]) begin
            armed_reg <= 1'b0;
        end
    end

    // One-cycle alignment strobe to all four consumers.
    always_ff @(posedge clock) begin
        if (srst) begin
            align_reg <= 1'b0;
        end else begin
            align_reg <= act;
        end
    end

    assign align_divider = align_reg;
    assign align_ddc     = align_reg;
    assign align_monitor = align_reg;
    assign align_framer  = align_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Setup and hold margin monitor.

    // Margins latch on each acted capture, so software sees that event's phase.
    always_ff @(posedge clock) begin
        if (srst) begin
            margin_reg <= link_sync_pkg::ZERO_BYTE;
        end else if (act) begin
            margin_reg <= {hold_phase, setup_phase};
        end
    end

    assign setup_f = setup_phase;
    assign hold_f  = hold_phase;

    // Classification of the new margin pair at capture time.
    assign either_err = (hold_f == link_sync_pkg::MARGIN_ZERO) && (setup_f == link_sync_pkg::MARGIN_ZERO);
    assign setup_err  = (hold_f == link_sync_pkg::MARGIN_ZERO) && (setup_f <= link_sync_pkg::SETUP_LOW_MAX);
    assign hold_err   = (setup_f == link_sync_pkg::MARGIN_ZERO) && (hold_f >= link_sync_pkg::HOLD_HIGH_MIN);
    // Setup of 8 or hold of 8 with the stated setup values raises neither flag.

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts and read port.

    // Sticky status; a read of the status register clears it, but a same-cycle event wins.
    always_comb begin
        irq_status_next = irq_status_reg;
        if (rd && reg_req.addr == link_sync_pkg::ADDR_IRQ_STATUS) begin
            irq_status_next = 4'h0;
        end
        if (act) begin
            irq_status_next[link_sync_pkg::IRQ_CAPTURE] = 1'b1;
        end
        if (act && (setup_err || either_err)) begin
            irq_status_next[link_sync_pkg::IRQ_SETUP_ERR] = 1'b1;
        end
        if (act && (hold_err || either_err)) begin
            irq_status_next[link_sync_pkg::IRQ_HOLD_ERR] = 1'b1;
        end
        if (cfg_bad) begin
            irq_status_next[link_sync_pkg::IRQ_BAD_CONFIG] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_status_reg <= 4'h0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read data stands only in the cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_reg <= link_sync_pkg::ZERO_BYTE;
        end else if (rd) begin
            unique case (reg_req.addr)
                link_sync_pkg::ADDR_SYSREF_CONTROL_A:   rdata_reg <= control_a_reg;
                link_sync_pkg::ADDR_SYSREF_CONTROL_B:   rdata_reg <= control_b_reg;
                link_sync_pkg::ADDR_SYSREF_MARGIN:      rdata_reg <= margin_reg;
                link_sync_pkg::ADDR_LINE_RATE_CONTROL:  rdata_reg <= line_rate_reg;
                link_sync_pkg::ADDR_LINK_QUICK_CONFIG:  rdata_reg <= quick_reg;
                link_sync_pkg::ADDR_LINK_FRAMES_PER_MF: rdata_reg <= {2'h0, kfm_reg};
                link_sync_pkg::ADDR_LINK_PARAMS:        rdata_reg <= {1'b0, cfg_now.lanes, 1'b0, cfg_now.octets};
                link_sync_pkg::ADDR_IRQ_STATUS:         rdata_reg <= {4'h0, irq_status_reg};
                link_sync_pkg::ADDR_IRQ_MASK:           rdata_reg <= {4'h0, irq_mask_reg};
                link_sync_pkg::ADDR_LINE_RATE_STATUS:   rdata_reg <= {3'h0, cfg_now.rate_mult};
                link_sync_pkg::ADDR_DECIMATION:         rdata_reg <= decim_reg;
                default:                                rdata_reg <= link_sync_pkg::ZERO_BYTE;
            endcase
        end else begin
            rdata_reg <= link_sync_pkg::ZERO_BYTE;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// ---- testbench/link_sync_properties.sv ----
// Concurrent checks on the ports of the link configuration and SYSREF capture block.
`timescale 1ns/1ns
module link_sync_properties (
    // Clock and reset.
    input wire logic                     clock,
    input wire logic                     srst,
    // Register port.
    input wire link_sync_pkg::reg_req_t  reg_req,
    input wire logic [7:0]               reg_rdata,
    // SYSREF side.
    input wire logic                     sysref_pin,
    input wire logic [3:0]               setup_phase,
    input wire logic [3:0]               hold_phase,
    // Alignment strobes.
    input wire logic                     align_divider,
    input wire logic                     align_ddc,
    input wire logic                     align_monitor,
    input wire logic                     align_framer,
    // Link settings and interrupt.
    input wire link_sync_pkg::link_cfg_t link_cfg,
    input wire logic [5:0]               frames_per_mf,
    input wire logic                     low_rate_mode,
    input wire logic                     high_density,
    input wire logic [3:0]               resolution_bits,
    input wire logic [1:0]               control_bits,
    input wire logic                     irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [7:0] ctl_a_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of control A, for the expected polarity.
    always_ff @(posedge clock) begin
        if (srst) begin
            ctl_a_reg <= 8'h00;
        end else if (reg_req.wr && reg_req.addr == link_sync_pkg::ADDR_SYSREF_CONTROL_A) begin
            ctl_a_reg <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A strobe follows its selected SYSREF transition by three cycles.
    a_align_together: assert property (
        align_divider == align_ddc && align_divider == align_monitor && align_divider == align_framer)
        else $error("alignment strobes disagree");
    a_align_single: assert property (align_divider |=> !align_divider)
        else $error("align strobe too long");
    a_align_cause: assert property (
        align_divider |-> $past(sysref_pin, 2) != ctl_a_reg[0] && $past(sysref_pin, 7) == ctl_a_reg[0])
        else $error("alignment without a selected SYSREF transition");
    a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_fixed_params: assert property (
        high_density == 1'b0 && resolution_bits == 4'h8 && control_bits == 2'h0)
        else $error("fixed sample parameters wrong");
    a_rate_mult: assert property (link_cfg.valid |-> link_cfg.rate_mult == 5'(20 / link_cfg.lanes))
        else $error("lane rate multiplier wrong");
    a_samples_frame: assert property (link_cfg.valid |->
        6'(link_cfg.lanes) * 6'(link_cfg.octets) == {1'b0, link_cfg.samples, 1'b0})
        else $error("samples per frame wrong");
    a_frames_legal: assert property (
        frames_per_mf[1:0] == 2'h0 && frames_per_mf >= 6'h08 && frames_per_mf <= 6'h20)
        else $error("frames per multiframe out of range");
endmodule

bind link_sync link_sync_properties props (.clock(clock), .srst(srst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sysref_pin(sysref_pin), .setup_phase(setup_phase), .hold_phase(hold_phase),
    .align_divider(align_divider), .align_ddc(align_ddc), .align_monitor(align_monitor),
    .align_framer(align_framer), .link_cfg(link_cfg), .frames_per_mf(frames_per_mf),
    .low_rate_mode(low_rate_mode), .high_density(high_density), .resolution_bits(resolution_bits),
    .control_bits(control_bits), .irq(irq));

// ---- testbench/sysref_source.sv ----
// Model of the SYSREF source and the clock-stage phase detectors.
`timescale 1ns/1ns
module sysref_source (
    // Clock.
    input wire logic  clock,
    // Toward the block.
    output logic       sysref_pin,
    output logic [3:0] setup_phase,
    output logic [3:0] hold_phase
);
    // Idle low with a clean margin reading.
    initial begin
        sysref_pin = 1'b0;
        setup_phase = 4'h8;
        hold_phase = 4'h8;
    end

    // Drives a level and holds it.
    task automatic drive_level(input logic level, input int hold_cycles);
        @(posedge clock);
        sysref_pin <= level;
        repeat (hold_cycles) @(posedge clock);
    endtask

    // Phase readings hold until changed.
    task automatic set_phase(input logic [3:0] setup, input logic [3:0] hold);
        @(posedge clock);
        setup_phase <= setup;
        hold_phase <= hold;
    endtask
endmodule

// ---- testbench/test_link_sync.sv ----
// Self-checking testbench of the link configuration and SYSREF capture block.
`timescale 1ns/1ns
module test_link_sync;
    logic clock, srst, sysref_pin, irq, low_rate_mode, high_density;
    logic align_divider, align_ddc, align_monitor, align_framer;
    logic [7:0] reg_rdata;
    logic [3:0] setup_phase, hold_phase, resolution_bits;
    logic [5:0] frames_per_mf;
    logic [1:0] control_bits;
    link_sync_pkg::reg_req_t reg_req;
    link_sync_pkg::link_cfg_t link_cfg;
    int error_cnt, n_checks, align_cnt;
    logic [7:0] codes [6] = '{8'h09, 8'h48, 8'h49, 8'h88, 8'h89, 8'h8A};
    logic [7:0] lanes_e [6] = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h04, 8'h04};
    logic [7:0] oct_e [6] = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h04};
    logic [7:0] smp_e [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h04, 8'h08};

    link_sync dut (.clock(clock), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .sysref_pin(sysref_pin),
        .setup_phase(setup_phase), .hold_phase(hold_phase), .align_divider(align_divider), .align_ddc(align_ddc),
        .align_monitor(align_monitor), .align_framer(align_framer), .link_cfg(link_cfg),
        .frames_per_mf(frames_per_mf), .low_rate_mode(low_rate_mode), .high_density(high_density),
        .resolution_bits(resolution_bits), .control_bits(control_bits), .irq(irq));
    sysref_source src (.clock(clock), .sysref_pin(sysref_pin), .setup_phase(setup_phase), .hold_phase(hold_phase));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, strobe counter and watchdog.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) if (align_divider === 1'b1) align_cnt++;
    initial begin
        repeat (50000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counts, verdict and end of run.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle strobes; read data taken the cycle after.
    task automatic reg_write(input logic [11:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req.wr <= 1'b0;
        #1;
    endtask
    task automatic reg_read(input logic [11:0] addr, input logic [7:0] exp, input string what);
        @(posedge clock);
        reg_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
        #1;
        chk8(what, exp, reg_rdata);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset();
        reg_read(12'h120, 8'h00, "control a reset");
        reg_read(12'h121, 8'h00, "control b reset");
        reg_read(12'h56E, 8'h00, "line rate reset");
        reg_read(12'h570, 8'h88, "quick config reset");
        reg_read(12'h7FF, 8'h00, "unmapped read");
        chk8("reset lanes", 8'h04, 8'(link_cfg.lanes));
    endtask
    // Every quick code, then K limits for four and one octets.
    task automatic t_quick();
        for (int i = 0; i < 6; i++) begin
            reg_write(12'h570, codes[i]);
            chk8("lanes", lanes_e[i], 8'(link_cfg.lanes));
            chk8("octets", oct_e[i], 8'(link_cfg.octets));
            chk8("samples", smp_e[i], 8'(link_cfg.samples));
            chk8("mult", 8'(20 / lanes_e[i]), 8'(link_cfg.rate_mult));
        end
        reg_write(12'h571, 8'h08);
        reg_read(12'h571, 8'h08, "k min four octets");
        reg_write(12'h571, 8'h0A);
        reg_read(12'h571, 8'h08, "k off step");
        reg_write(12'h571, 8'h20);
        reg_write(12'h570, 8'h88);
        reg_write(12'h571, 8'h10);
        reg_read(12'h571, 8'h20, "k below one octet min");
        reg_write(12'h571, 8'h14);
        reg_read(12'h571, 8'h14, "k one octet min");
    endtask
    // Bad code raises irq only when unmasked; a status read clears it.
    task automatic t_irq();
        reg_read(12'h580, 8'h00, "status idle");
        reg_write(12'h581, 8'h00);
        reg_write(12'h570, 8'h01);
        chk8("masked irq", 8'h00, 8'(irq));
        reg_write(12'h581, 8'h08);
        chk8("invalid valid", 8'h00, 8'(link_cfg.valid));
        chk8("unmasked irq", 8'h01, 8'(irq));
        reg_write(12'h570, 8'h88);
        reg_read(12'h580, 8'h08, "bad config status");
        reg_read(12'h580, 8'h00, "status cleared");
        chk8("irq cleared", 8'h00, 8'(irq));
        reg_write(12'h581, 8'hFF);
    endtask
    task automatic t_low_rate();
        reg_write(12'h56E, 8'h10);
        @(posedge clock);
        #1;
        chk8("low rate", 8'h01, 8'(low_rate_mode));
        reg_read(12'h56E, 8'h10, "line rate readback");
        reg_write(12'h56E, 8'h00);
    endtask
    // Pulses SYSREF under given controls and phases; judges strobes, margin, status.
    task automatic capture(input logic [7:0] ca, input logic [7:0] cb, input logic [3:0] su, input logic [3:0] ho,
                           input int pulses, input int aligns, input logic [7:0] status);
        int start;
        reg_write(12'h120, ca);
        reg_write(12'h121, cb);
        src.set_phase(su, ho);
        start = align_cnt;
        repeat (pulses) begin
            src.drive_level(1'b1, 12);
            src.drive_level(1'b0, 12);
        end
        chk8("align count", 8'(aligns), 8'(align_cnt - start));
        chk8("capture irq", 8'(status != 8'h00), 8'(irq));
        if (aligns > 0) reg_read(12'h128, {ho, su}, "margin");
        reg_read(12'h580, status, "capture status");
    endtask
    // Falling polarity: only the falling half acts.
    task automatic t_polarity();
        int start;
        reg_write(12'h120, 8'h01);
        start = align_cnt;
        src.drive_level(1'b1, 12);
        chk8("rise ignored", 8'h00, 8'(align_cnt - start));
        src.drive_level(1'b0, 12);
        chk8("fall acted", 8'h01, 8'(align_cnt - start));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        error_cnt = 0;
        n_checks = 0;
        align_cnt = 0;
        srst = 1'b1;
        reg_req = '0;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_quick();
        reg_write(12'h571, 8'h20);
        t_irq();
        t_low_rate();
        capture(8'h00, 8'h00, 4'h8, 4'h3, 1, 1, 8'h01);
        capture(8'h02, 8'h00, 4'h9, 4'h8, 1, 1, 8'h01);
        capture(8'h00, 8'h03, 4'h5, 4'h0, 4, 1, 8'h03);
        capture(8'h00, 8'h03, 4'h8, 4'h8, 3, 0, 8'h00);
        capture(8'h00, 8'h0F, 4'h0, 4'hB, 16, 1, 8'h05);
        capture(8'h00, 8'h00, 4'h0, 4'h0, 1, 1, 8'h07);
        capture(8'h04, 8'h00, 4'h8, 4'h8, 2, 1, 8'h01);
        t_polarity();
        report_and_stop();
    end
endmodule
